// ==== design/pscp_top.sv ====
// Function
// [RL1] After power-up, settings follow the sleep and strap pins in pin-only mode, no reset needed.
// [RL2] Register strap-equivalent bits act only while register priority is high; else straps rule.
// [RL3] Sleep pin high forces global power down; global sleep bit acts only when pin low.
// [RL4] Serial use: coarse gain from gain bit only under register priority, else 0 dB.
// [RL5] Serial use: reference source comes only from the reference register bit.
// [RL6] Serial use: patterns from test output select field, power down from global sleep bit.
// [RL7] Pin-only: clock low, data high gives sync pattern; both low is normal conversion.
// [RL8] Pin-only: clock high, data low powers down channels, references, multiplier and buffers.
// [RL9] Pin-only: clock and data both high gives deskew pattern on every channel.
// [RL10] Pin-only select levels: ext 0 dB, ext 3.5 dB, int 3.5 dB, int 0 dB.
// [RL11] Link strap levels: double-rate 1-wire, unused, single-rate 2-wire, double-rate 2-wire.
// [RL12] Serialize strap in single-rate 2-wire: 14x fall, 16x fall, 16x rise, 14x rise.
// [RL13] Order strap levels: MSB two's, MSB offset, LSB offset, LSB two's complement.
// [RL14] Outside party ties the reserved strap to ground.
// [RL15] Outside party resets registers before use, then holds the reset pin low.
// [RL16] Register priority is bit 10 of register 0x0D; high hands straps to registers.
// [RL17] Soft clear bit high in register 0x00 restores defaults and self-clears.
// [RL18] Each multi-level strap arrives as a two-bit level code, zero lowest.
// [RL19] Unused link strap level decodes as double-rate bit clock, 1-wire output.
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "pscp_cfg.svh"

module pscp_top (
  input wire logic core_clk, // 20 MHz block clock
  input wire logic reset, // Async reset, high
  input wire logic serial_port_en_pin, // High when the serial port is in use
  input wire logic sleep_pin, // Dedicated global sleep pin
  input wire logic serial_clk_pin, // Serial clock pin, a control level in pin-only mode
  input wire logic serial_in_pin, // Serial data pin, a control level in pin-only mode
  input wire logic [1:0] serial_select_pin, // Level code of the select pin
  input wire logic [1:0] link_width_strap, // Level code of the link strap
  input wire logic [1:0] serialize_edge_strap, // Level code of the serialize strap
  input wire logic [1:0] reserved_strap, // Level code of the reserved strap
  input wire logic [1:0] order_format_strap, // Level code of the order strap
  input wire logic [4:0] reg_addr, // Register address
  input wire logic [10:0] reg_wdata, // Register write data
  input wire logic reg_wr, // Register write strobe
  input wire logic reg_rd, // Register read strobe
  output logic [10:0] reg_rdata, // Register read data
  output logic global_pdn_q, // Global power down
  output logic [3:0] channel_pdn_q, // Per-channel power down
  output logic refs_pdn_q, // Internal references powered down
  output logic pll_pdn_q, // Clock multiplier powered down
  output logic outbuf_pdn_q, // Output buffers powered down
  output logic ref_internal_q, // Internal reference selected
  output logic gain_3p5_q, // 3.5 dB coarse gain, else 0 dB
  output logic [2:0] test_pattern_q, // One-hot output pattern select
  output logic ddr_bitclk_q, // Double-rate bit clock
  output logic two_wire_q, // 2-wire output
  output logic ser16_q, // 16x serialization, else 14x
  output logic capture_rising_q, // Capture on rising edge
  output logic lsb_first_q, // LSB first
  output logic offset_binary_q, // Offset binary, else two's complement
  output logic reserved_strap_bad_q // Reserved strap not at ground
);

  logic [3:0] ctl_s;
  logic [9:0] strap_s;
  logic port_en_s;
  logic sleep_s;
  logic sclk_s;
  logic serial_in_pin_s;
  pscp_pkg::pscp_level_t sel_lvl;
  pscp_pkg::pscp_level_t link_lvl;
  pscp_pkg::pscp_level_t ser_lvl;
  pscp_pkg::pscp_level_t rsv_lvl;
  pscp_pkg::pscp_level_t order_lvl;

  logic global_sleep_q;
  logic [3:0] ch_pdn_q;
  logic ref_int_q;
  logic [2:0] pattern_q;
  logic override_q;
  logic [5:0] modes_q;
  logic gain_q;
  logic [10:0] status;

  logic use_regs;
  pscp_pkg::pscp_level_t link_eff;
  pscp_pkg::pscp_level_t ser_eff;
  pscp_pkg::pscp_level_t order_eff;
  logic mode_pdn;
  logic pdn_d;
  pscp_pkg::pscp_pattern_e pattern_d;
  logic ref_int_d;
  logic gain_d;
  logic ddr_d;
  logic two_wire_d;
  logic ser16_d;
  logic rising_d;
  logic lsb_d;
  logic ob_d;

  // Every pin level is asynchronous to core_clk; straps are only static on paper
  pscp_sync #(
    .W(4)
  ) u_ctl_sync (
    .core_clk(core_clk),
    .reset(reset),
    .async_in({serial_port_en_pin, sleep_pin, serial_clk_pin, serial_in_pin}),
    .sync_out(ctl_s)
  );

  pscp_sync #(
    .W(10)
  ) u_strap_sync (
    .core_clk(core_clk),
    .reset(reset),
    .async_in({serial_select_pin, link_width_strap, serialize_edge_strap, reserved_strap, order_format_strap}),
    .sync_out(strap_s)
  );

  assign port_en_s = ctl_s[3];
  assign sleep_s = ctl_s[2];
  assign sclk_s = ctl_s[1];
  assign serial_in_pin_s = ctl_s[0];
  assign sel_lvl = strap_s[9:8]; // [RL18]
  assign link_lvl = strap_s[7:6];
  assign ser_lvl = strap_s[5:4];
  assign rsv_lvl = strap_s[3:2];
  assign order_lvl = strap_s[1:0];

  pscp_regs u_regs (
    .core_clk(core_clk),
    .reset(reset),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .status_in(status),
    .reg_rdata(reg_rdata),
    .global_sleep_q(global_sleep_q),
    .ch_pdn_q(ch_pdn_q),
    .ref_int_q(ref_int_q),
    .pattern_q(pattern_q),
    .override_q(override_q),
    .modes_q(modes_q),
    .gain_q(gain_q)
  );

  assign status = {global_pdn_q, ref_internal_q, gain_3p5_q, test_pattern_q[2], test_pattern_q[1],
                   ddr_bitclk_q, two_wire_q, ser16_q, capture_rising_q, lsb_first_q, offset_binary_q};

  // Register codes reuse the strap level encoding so one decoder serves both sources
  assign use_regs = port_en_s && override_q; // [RL2] [RL16]
  assign link_eff = use_regs ? modes_q[`PSCP_MODES_LINK_LSB +: 2] : link_lvl; // [RL2]
  assign ser_eff = use_regs ? modes_q[`PSCP_MODES_SER_LSB +: 2] : ser_lvl; // [RL2]
  assign order_eff = use_regs ? modes_q[`PSCP_MODES_ORDER_LSB +: 2] : order_lvl; // [RL2]

  always_comb begin
    ddr_d = 1'b1;
    two_wire_d = 1'b0;
    unique case (link_eff)
      `PSCP_LVL0, `PSCP_LVL1: begin
        ddr_d = 1'b1; // [RL11] [RL19]
        two_wire_d = 1'b0;
      end
      `PSCP_LVL2: begin
        ddr_d = 1'b0; // [RL11]
        two_wire_d = 1'b1;
      end
      `PSCP_LVL3: begin
        ddr_d = 1'b1; // [RL11]
        two_wire_d = 1'b1;
      end
    endcase
  end

  // Serialization choice is decoded always; the link only honours it in single-rate 2-wire mode
  always_comb begin
    ser16_d = 1'b0;
    rising_d = 1'b0;
    unique case (ser_eff)
      `PSCP_LVL0: begin
        ser16_d = 1'b0; // [RL12]
        rising_d = 1'b0;
      end
      `PSCP_LVL1: begin
        ser16_d = 1'b1; // [RL12]
        rising_d = 1'b0;
      end
      `PSCP_LVL2: begin
        ser16_d = 1'b1; // [RL12]
        rising_d = 1'b1;
      end
      `PSCP_LVL3: begin
        ser16_d = 1'b0; // [RL12]
        rising_d = 1'b1;
      end
    endcase
  end

  always_comb begin
    lsb_d = 1'b0;
    ob_d = 1'b0;
    unique case (order_eff)
      `PSCP_LVL0: begin
        lsb_d = 1'b0; // [RL13]
        ob_d = 1'b0;
      end
      `PSCP_LVL1: begin
        lsb_d = 1'b0; // [RL13]
        ob_d = 1'b1;
      end
      `PSCP_LVL2: begin
        lsb_d = 1'b1; // [RL13]
        ob_d = 1'b1;
      end
      `PSCP_LVL3: begin
        lsb_d = 1'b1; // [RL13]
        ob_d = 1'b0;
      end
    endcase
  end

  // Pattern and power down: pin pair in pin-only mode, registers once the serial port is in use
  always_comb begin
    pattern_d = pscp_pkg::PSCP_OUT_NORMAL;
    mode_pdn = 1'b0;
    if (port_en_s) begin
      mode_pdn = global_sleep_q; // [RL6]
      if (pattern_q == `PSCP_PAT_SYNC) begin
        pattern_d = pscp_pkg::PSCP_OUT_SYNC; // [RL6]
      end else if (pattern_q == `PSCP_PAT_DESKEW) begin
        pattern_d = pscp_pkg::PSCP_OUT_DESKEW; // [RL6]
      end
    end else begin
      unique case ({sclk_s, serial_in_pin_s})
        2'b00: pattern_d = pscp_pkg::PSCP_OUT_NORMAL; // [RL7]
        2'b01: pattern_d = pscp_pkg::PSCP_OUT_SYNC; // [RL7]
        2'b10: mode_pdn = 1'b1; // [RL8]
        2'b11: pattern_d = pscp_pkg::PSCP_OUT_DESKEW; // [RL9]
      endcase
    end
  end

  assign pdn_d = sleep_s || mode_pdn; // [RL3]

  always_comb begin
    ref_int_d = 1'b0;
    gain_d = 1'b0;
    if (port_en_s) begin
      ref_int_d = ref_int_q; // [RL5]
      gain_d = override_q && gain_q; // [RL4]
    end else begin
      unique case (sel_lvl)
        `PSCP_LVL0: begin
          ref_int_d = 1'b0; // [RL10]
          gain_d = 1'b0;
        end
        `PSCP_LVL1: begin
          ref_int_d = 1'b0; // [RL10]
          gain_d = 1'b1;
        end
        `PSCP_LVL2: begin
          ref_int_d = 1'b1; // [RL10]
          gain_d = 1'b1;
        end
        `PSCP_LVL3: begin
          ref_int_d = 1'b1; // [RL10]
          gain_d = 1'b0;
        end
      endcase
    end
  end

  // Outputs track the pins continuously, so straps apply after power-up with or without reset
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      global_pdn_q <= 1'b0;
      refs_pdn_q <= 1'b0;
      pll_pdn_q <= 1'b0;
      outbuf_pdn_q <= 1'b0;
      channel_pdn_q <= 4'h0;
    end else begin
      global_pdn_q <= pdn_d; // [RL1] [RL3]
      refs_pdn_q <= pdn_d; // [RL8]
      pll_pdn_q <= pdn_d; // [RL8]
      outbuf_pdn_q <= pdn_d; // [RL8]
      channel_pdn_q <= {4{pdn_d}} | (port_en_s ? ch_pdn_q : 4'h0); // [RL8]
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ref_internal_q <= 1'b0;
      gain_3p5_q <= 1'b0;
      test_pattern_q <= pscp_pkg::PSCP_OUT_NORMAL;
    end else begin
      ref_internal_q <= ref_int_d; // [RL1]
      gain_3p5_q <= gain_d;
      test_pattern_q <= pattern_d;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ddr_bitclk_q <= 1'b1;
      two_wire_q <= 1'b0;
      ser16_q <= 1'b0;
      capture_rising_q <= 1'b0;
      lsb_first_q <= 1'b0;
      offset_binary_q <= 1'b0;
    end else begin
      ddr_bitclk_q <= ddr_d; // [RL1]
      two_wire_q <= two_wire_d;
      ser16_q <= ser16_d;
      capture_rising_q <= rising_d;
      lsb_first_q <= lsb_d;
      offset_binary_q <= ob_d;
    end
  end

  // Flags a board that breaks the ground tie on the reserved strap
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      reserved_strap_bad_q <= 1'b0;
    end else begin
      reserved_strap_bad_q <= rsv_lvl != `PSCP_LVL0; // [RL14]
    end
  end

  sleep_force_a: assert property (@(posedge core_clk) disable iff (reset) // [RL3]
    sleep_s |=> global_pdn_q && pll_pdn_q && (channel_pdn_q == 4'hF))
    else $error("sleep pin did not force global power down");

  sleep_bit_a: assert property (@(posedge core_clk) disable iff (reset) // [RL6]
    (port_en_s && !sleep_s) |=> (global_pdn_q == $past(global_sleep_q)))
    else $error("global sleep bit not obeyed while sleep pin low");

  pin_sync_a: assert property (@(posedge core_clk) disable iff (reset) // [RL7]
    (!port_en_s && !sleep_s && !sclk_s && serial_in_pin_s) |=> (test_pattern_q == pscp_pkg::PSCP_OUT_SYNC) && !global_pdn_q)
    else $error("sync pattern not selected by pin pair");

  pin_pdn_a: assert property (@(posedge core_clk) disable iff (reset) // [RL8]
    (!port_en_s && sclk_s && !serial_in_pin_s) |=> global_pdn_q && refs_pdn_q && outbuf_pdn_q)
    else $error("pin pair power down not applied");

  pin_deskew_a: assert property (@(posedge core_clk) disable iff (reset) // [RL9]
    (!port_en_s && sclk_s && serial_in_pin_s) |=> (test_pattern_q == pscp_pkg::PSCP_OUT_DESKEW))
    else $error("deskew pattern not selected by pin pair");

  sel_level_a: assert property (@(posedge core_clk) disable iff (reset) // [RL10]
    (!port_en_s && sel_lvl == `PSCP_LVL2) |=> ref_internal_q && gain_3p5_q)
    else $error("select level two not internal reference with gain");

  gain_default_a: assert property (@(posedge core_clk) disable iff (reset) // [RL4]
    (port_en_s && !override_q) |=> !gain_3p5_q)
    else $error("coarse gain not 0 dB without register priority");

  ref_reg_a: assert property (@(posedge core_clk) disable iff (reset) // [RL5]
    port_en_s |=> (ref_internal_q == $past(ref_int_q)))
    else $error("reference source not taken from register bit");

  link_unused_a: assert property (@(posedge core_clk) disable iff (reset) // [RL19]
    (link_eff == `PSCP_LVL1) |=> ddr_bitclk_q && !two_wire_q)
    else $error("unused link level not decoded as lowest level");

  strap_priority_a: assert property (@(posedge core_clk) disable iff (reset) // [RL2]
    !use_regs |=> (lsb_first_q == $past(order_lvl[1])) && (ser16_q == $past(ser_lvl[0] ^ ser_lvl[1])))
    else $error("strap levels not obeyed without register priority");

  soft_clear_a: assert property (@(posedge core_clk) disable iff (reset) // [RL17]
    (reg_wr && reg_addr == `PSCP_ADDR_MAIN && reg_wdata[`PSCP_MAIN_SOFT_CLEAR])
      |=> !override_q && !global_sleep_q && (modes_q == 6'h00) ##1 (reg_rdata[10] == 1'b0))
    else $error("soft clear did not restore defaults");

  order_decode_a: assert property (@(posedge core_clk) disable iff (reset) // [RL13]
    (order_eff == `PSCP_LVL3) |=> lsb_first_q && !offset_binary_q)
    else $error("order level three not LSB first two's complement");

endmodule : pscp_top

`default_nettype wire

// ==== design/pscp_cfg.svh ====
`ifndef PSCP_CFG_SVH
`define PSCP_CFG_SVH

// Register addresses on the 5-bit register port
`define PSCP_ADDR_MAIN 5'h00
`define PSCP_ADDR_PATTERN 5'h0A
`define PSCP_ADDR_PRIORITY 5'h0D
`define PSCP_ADDR_MODES 5'h10
`define PSCP_ADDR_GAIN 5'h11
`define PSCP_ADDR_STATUS 5'h1F

// Field positions in the main register
`define PSCP_MAIN_SOFT_CLEAR 10
`define PSCP_MAIN_REF_INT 5
`define PSCP_MAIN_CH_PDN_LSB 1
`define PSCP_MAIN_GLOBAL_SLEEP 0

// Field positions in the other registers
`define PSCP_PATTERN_LSB 5
`define PSCP_PRIORITY_BIT 10
`define PSCP_MODES_LINK_LSB 0
`define PSCP_MODES_SER_LSB 2
`define PSCP_MODES_ORDER_LSB 4
`define PSCP_GAIN_BIT 0

// Test output select field codes
`define PSCP_PAT_NORMAL 3'h0
`define PSCP_PAT_SYNC 3'h1
`define PSCP_PAT_DESKEW 3'h2

// Reset values
`define PSCP_MAIN_RST 11'h000
`define PSCP_PATTERN_RST 3'h0
`define PSCP_PRIORITY_RST 1'h0
`define PSCP_MODES_RST 6'h00
`define PSCP_GAIN_RST 1'h0

// Strap level codes
`define PSCP_LVL0 2'h0
`define PSCP_LVL1 2'h1
`define PSCP_LVL2 2'h2
`define PSCP_LVL3 2'h3

`endif

// ==== design/pscp_pkg.sv ====
package pscp_pkg;

  typedef logic [1:0] pscp_level_t;

  typedef enum logic [2:0] {
    PSCP_OUT_NORMAL = 3'b001,
    PSCP_OUT_SYNC = 3'b010,
    PSCP_OUT_DESKEW = 3'b100
  } pscp_pattern_e;

endpackage : pscp_pkg

// ==== design/pscp_sync.sv ====
`timescale 1ns/10ps
`default_nettype none

module pscp_sync #(
  parameter int W = 1
) (
  input wire logic core_clk, // Block clock
  input wire logic reset, // Async reset, high
  input wire logic [W-1:0] async_in, // Level from outside the domain
  output logic [W-1:0] sync_out // Level after two flops
);

  logic [W-1:0] meta_q;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : pscp_sync

`default_nettype wire

// ==== design/pscp_regs.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "pscp_cfg.svh"

module pscp_regs (
  input wire logic core_clk, // Block clock
  input wire logic reset, // Async reset, high
  input wire logic [4:0] reg_addr, // Register address
  input wire logic [10:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [10:0] status_in, // Effective settings for readback
  output logic [10:0] reg_rdata, // Read data, cycle after strobe
  output logic global_sleep_q, // Global sleep bit
  output logic [3:0] ch_pdn_q, // Per-channel power down bits
  output logic ref_int_q, // Reference source bit
  output logic [2:0] pattern_q, // Test output select field
  output logic override_q, // Register-priority bit
  output logic [5:0] modes_q, // Register strap-equivalent codes
  output logic gain_q // Gain step bit
);

  logic [10:0] main_q;
  logic soft_clear;

  // Soft clear restores defaults at once; the bit itself is never stored, so it reads back low
  assign soft_clear = reg_wr && reg_addr == `PSCP_ADDR_MAIN && reg_wdata[`PSCP_MAIN_SOFT_CLEAR]; // [RL17]

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      main_q <= `PSCP_MAIN_RST;
      pattern_q <= `PSCP_PATTERN_RST;
      override_q <= `PSCP_PRIORITY_RST;
      modes_q <= `PSCP_MODES_RST;
      gain_q <= `PSCP_GAIN_RST;
    end else if (soft_clear) begin
      main_q <= `PSCP_MAIN_RST; // [RL17]
      pattern_q <= `PSCP_PATTERN_RST;
      override_q <= `PSCP_PRIORITY_RST;
      modes_q <= `PSCP_MODES_RST;
      gain_q <= `PSCP_GAIN_RST;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `PSCP_ADDR_MAIN: main_q <= {1'b0, 4'h0, reg_wdata[5:0]};
        `PSCP_ADDR_PATTERN: pattern_q <= reg_wdata[`PSCP_PATTERN_LSB +: 3];
        `PSCP_ADDR_PRIORITY: override_q <= reg_wdata[`PSCP_PRIORITY_BIT]; // [RL16]
        `PSCP_ADDR_MODES: modes_q <= reg_wdata[5:0];
        `PSCP_ADDR_GAIN: gain_q <= reg_wdata[`PSCP_GAIN_BIT];
        default: ;
      endcase
    end
  end

  assign global_sleep_q = main_q[`PSCP_MAIN_GLOBAL_SLEEP];
  assign ch_pdn_q = main_q[`PSCP_MAIN_CH_PDN_LSB +: 4];
  assign ref_int_q = main_q[`PSCP_MAIN_REF_INT];

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 11'h000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `PSCP_ADDR_MAIN: reg_rdata <= main_q;
        `PSCP_ADDR_PATTERN: reg_rdata <= {3'h0, pattern_q, 5'h00};
        `PSCP_ADDR_PRIORITY: reg_rdata <= {override_q, 10'h000};
        `PSCP_ADDR_MODES: reg_rdata <= {5'h00, modes_q};
        `PSCP_ADDR_GAIN: reg_rdata <= {10'h000, gain_q};
        `PSCP_ADDR_STATUS: reg_rdata <= status_in;
        default: reg_rdata <= 11'h000;
      endcase
    end else begin
      reg_rdata <= 11'h000;
    end
  end

endmodule : pscp_regs

`default_nettype wire

// ==== verif/pscp_board.sv ====
`timescale 1ns/10ps
`default_nettype none

module pscp_board (
  input wire logic want_serial, // Controller uses the serial port
  input wire logic want_sleep, // Sleep level wanted
  input wire logic [1:0] want_ctl, // Clock and data pin pair, clock high
  input wire logic [1:0] want_sel, // Select pin level
  input wire logic [1:0] want_link, // Link strap level
  input wire logic [1:0] want_ser, // Serialize strap level
  input wire logic [1:0] want_ord, // Order strap level
  output logic serial_port_en_pin, // To the device
  output logic sleep_pin, // To the device
  output logic serial_clk_pin, // To the device
  output logic serial_in_pin, // To the device
  output logic [1:0] serial_select_pin, // To the device
  output logic [1:0] link_width_strap, // To the device
  output logic [1:0] serialize_edge_strap, // To the device
  output logic [1:0] reserved_strap, // To the device
  output logic [1:0] order_format_strap // To the device
);
  // Resistor strings hold their levels from power-up, no clocking involved
  assign serial_port_en_pin = want_serial;
  assign sleep_pin = want_sleep;
  assign serial_clk_pin = want_ctl[1];
  assign serial_in_pin = want_ctl[0];
  assign serial_select_pin = want_sel;
  assign link_width_strap = want_link;
  assign serialize_edge_strap = want_ser;
  assign order_format_strap = want_ord;
  assign reserved_strap = 2'h0;
endmodule : pscp_board

`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "pscp_cfg.svh"

module tb;
  logic core_clk, reset, serial, sleep, reg_wr, reg_rd;
  logic [1:0] ctl, sel, lk, se, od;
  logic [4:0] reg_addr;
  logic [10:0] reg_wdata, reg_rdata;
  logic [18:0] obs;
  int n_mismatch, checks_done;
  wire logic p_ser, p_slp, p_clk, p_in;
  wire logic [1:0] p_sel, p_lk, p_se, p_rs, p_od;
  logic global_pdn_q, refs_pdn_q, pll_pdn_q, outbuf_pdn_q, ref_internal_q, gain_3p5_q;
  logic ddr_bitclk_q, two_wire_q, ser16_q, capture_rising_q, lsb_first_q, offset_binary_q;
  logic [3:0] channel_pdn_q;
  logic [2:0] test_pattern_q;
  logic rsv_bad;

  pscp_board board_u (.want_serial(serial), .want_sleep(sleep), .want_ctl(ctl), .want_sel(sel),
    .want_link(lk), .want_ser(se), .want_ord(od), .serial_port_en_pin(p_ser), .sleep_pin(p_slp),
    .serial_clk_pin(p_clk), .serial_in_pin(p_in), .serial_select_pin(p_sel), .link_width_strap(p_lk),
    .serialize_edge_strap(p_se), .reserved_strap(p_rs), .order_format_strap(p_od));

  pscp_top dut_u (.core_clk(core_clk), .reset(reset), .serial_port_en_pin(p_ser), .sleep_pin(p_slp),
    .serial_clk_pin(p_clk), .serial_in_pin(p_in), .serial_select_pin(p_sel), .link_width_strap(p_lk),
    .serialize_edge_strap(p_se), .reserved_strap(p_rs), .order_format_strap(p_od),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .global_pdn_q(global_pdn_q), .channel_pdn_q(channel_pdn_q), .refs_pdn_q(refs_pdn_q),
    .pll_pdn_q(pll_pdn_q), .outbuf_pdn_q(outbuf_pdn_q), .ref_internal_q(ref_internal_q),
    .gain_3p5_q(gain_3p5_q), .test_pattern_q(test_pattern_q), .ddr_bitclk_q(ddr_bitclk_q),
    .two_wire_q(two_wire_q), .ser16_q(ser16_q), .capture_rising_q(capture_rising_q),
    .lsb_first_q(lsb_first_q), .offset_binary_q(offset_binary_q), .reserved_strap_bad_q(rsv_bad));

  assign obs = {global_pdn_q, channel_pdn_q, refs_pdn_q, pll_pdn_q, outbuf_pdn_q, ref_internal_q,
    gain_3p5_q, test_pattern_q, ddr_bitclk_q, two_wire_q, ser16_q, capture_rising_q, lsb_first_q,
    offset_binary_q};

  // Expected output word worked out from the level tables
  function automatic logic [18:0] expv(input logic pdn, input logic [3:0] chp, input logic rf,
    input logic gn, input logic [2:0] pat, input logic [1:0] l, input logic [1:0] s, input logic [1:0] o);
    logic [1:0] lw, sw, ow;
    lw = (l == 2'h2) ? 2'b01 : (l == 2'h3) ? 2'b11 : 2'b10;
    sw = (s == 2'h0) ? 2'b00 : (s == 2'h1) ? 2'b10 : (s == 2'h2) ? 2'b11 : 2'b01;
    ow = (o == 2'h0) ? 2'b00 : (o == 2'h1) ? 2'b01 : (o == 2'h2) ? 2'b11 : 2'b10;
    return {pdn, chp | {4{pdn}}, {3{pdn}}, rf, gn, pat, lw, sw, ow};
  endfunction : expv

  task automatic check(input logic [18:0] seen, input logic [18:0] want);
    checks_done++;
    if (seen !== want) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, seen, want);
    end
  endtask : check

  task automatic settle();
    repeat (4) @(posedge core_clk);
    #1;
  endtask : settle

  task automatic wr(input logic [4:0] a, input logic [10:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe, then drops to zero
  task automatic rd(input logic [4:0] a, input logic [10:0] want);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    check({8'h00, reg_rdata}, {8'h00, want});
    @(posedge core_clk);
    #1;
    check({8'h00, reg_rdata}, 19'h0_0000);
  endtask : rd

  task automatic complete_run();
    $display("mismatches %0d, comparisons %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  initial begin
    #100000;
    n_mismatch++;
    complete_run();
  end

  initial begin
    logic [2:0] pats [4];
    logic [2:0] pexp [4];
    pats = '{3'h1, 3'h2, 3'h0, 3'h5};
    pexp = '{3'b010, 3'b100, 3'b001, 3'b001};
    n_mismatch = 0;
    checks_done = 0;
    reset = 1'b1;
    {serial, sleep, ctl, sel, lk, se, od} = 12'h000;
    {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h0_0000;
    repeat (11) @(posedge core_clk);
    #1;
    check(obs, expv(1'b0, 4'h0, 1'b0, 1'b0, 3'b001, 2'h0, 2'h0, 2'h0));
    @(posedge core_clk);
    reset <= 1'b0;
    // Pin-only control, every level of the pin pair, select pin and link, serialize and order straps
    for (int i = 0; i < 4; i++) begin
      ctl <= 2'(i);
      sel <= 2'(i);
      lk <= 2'(i);
      se <= 2'(i);
      od <= 2'(i);
      settle();
      check(obs, expv(i == 2, 4'h0, i >= 2, i == 1 || i == 2, (i == 1) ? 3'b010 : (i == 3) ? 3'b100 : 3'b001,
        2'(i), 2'(i), 2'(i)));
    end
    ctl <= 2'h0;
    sleep <= 1'b1;
    settle();
    check(obs, expv(1'b1, 4'h0, 1'b1, 1'b0, 3'b001, 2'h3, 2'h3, 2'h3));
    // Serial port in use; pin pair and select level must be ignored
    sleep <= 1'b0;
    serial <= 1'b1;
    ctl <= 2'h3;
    sel <= 2'h2;
    lk <= 2'h2;
    se <= 2'h1;
    od <= 2'h3;
    wr(`PSCP_ADDR_MODES, 11'h01B);
    wr(`PSCP_ADDR_GAIN, 11'h001);
    settle();
    check(obs, expv(1'b0, 4'h0, 1'b0, 1'b0, 3'b001, 2'h2, 2'h1, 2'h3));
    wr(`PSCP_ADDR_PRIORITY, 11'h400);
    settle();
    check(obs, expv(1'b0, 4'h0, 1'b0, 1'b1, 3'b001, 2'h3, 2'h2, 2'h1));
    rd(`PSCP_ADDR_PRIORITY, 11'h400);
    // Status word: pdn, ref, gain, deskew, sync, ddr, 2-wire, 16x, rising, lsb, offset
    rd(`PSCP_ADDR_STATUS, 11'h13D);
    for (int k = 0; k < 4; k++) begin
      wr(`PSCP_ADDR_PATTERN, {3'h0, pats[k], 5'h00});
      settle();
      check(obs, expv(1'b0, 4'h0, 1'b0, 1'b1, pexp[k], 2'h3, 2'h2, 2'h1));
    end
    wr(`PSCP_ADDR_MAIN, 11'h02A);
    settle();
    check(obs, expv(1'b0, 4'h5, 1'b1, 1'b1, 3'b001, 2'h3, 2'h2, 2'h1));
    wr(`PSCP_ADDR_MAIN, 11'h02B);
    settle();
    check(obs, expv(1'b1, 4'h5, 1'b1, 1'b1, 3'b001, 2'h3, 2'h2, 2'h1));
    wr(`PSCP_ADDR_MAIN, 11'h02A);
    sleep <= 1'b1;
    settle();
    check(obs, expv(1'b1, 4'h5, 1'b1, 1'b1, 3'b001, 2'h3, 2'h2, 2'h1));
    sleep <= 1'b0;
    settle();
    check(obs, expv(1'b0, 4'h5, 1'b1, 1'b1, 3'b001, 2'h3, 2'h2, 2'h1));
    // Soft clear restores every register and drops itself
    wr(`PSCP_ADDR_MAIN, 11'h400);
    settle();
    check(obs, expv(1'b0, 4'h0, 1'b0, 1'b0, 3'b001, 2'h2, 2'h1, 2'h3));
    rd(`PSCP_ADDR_MAIN, 11'h000);
    rd(`PSCP_ADDR_PRIORITY, 11'h000);
    rd(5'h05, 11'h000);
    check({18'h0_0000, rsv_bad}, 19'h0_0000);
    complete_run();
  end
endmodule : tb

`default_nettype wire
